/* src/fpac_pkg.sv */
// Shared constants and carrier types for the access control block.
// Assumes a system clock and a separate debug link clock.
package fpac_pkg;

    // Flash controller variants.
    typedef enum logic [1:0] {
        FPAC_VAR_SMALL = 2'b00,
        FPAC_VAR_MID = 2'b01,
        FPAC_VAR_LARGE = 2'b10
    } fpac_variant_t;

    // Debug access port register indices.
    localparam logic [1:0] DBG_STATUS_IDX = 2'h0;
    localparam logic [1:0] DBG_CTRL_IDX = 2'h1;
    localparam logic [1:0] DBG_ID_IDX = 2'h3;

    // Status field positions.
    localparam int ST_ERASE_BUSY_POS = 0;
    localparam int ST_FLASH_READY_POS = 1;
    localparam int ST_SYS_SECURE_POS = 2;

    // Control field positions.
    localparam int CT_MASS_ERASE_POS = 0;
    localparam int CT_SYS_RESET_REQ_POS = 3;
    localparam int CT_CORE_HOLD_POS = 4;

    // Identification value; arbitrary.
    localparam logic [7:0] DBG_ID_VALUE = 8'h5a;

    // Reset values of the control fields.
    localparam logic CT_SYS_RESET_REQ_RST = 1'b0;
    localparam logic CT_CORE_HOLD_RST = 1'b0;

    // Serial programming port operations.
    typedef enum logic [1:0] {
        SP_OP_PROGRAM = 2'b00,
        SP_OP_SECTION = 2'b01,
        SP_OP_ERASE_SECTOR = 2'b10,
        SP_OP_DIRECT = 2'b11
    } fpac_sp_op_t;

    // Command codes loaded into the flash command object registers.
    localparam logic [7:0] FC_PROGRAM_LONGWORD = 8'h01;
    localparam logic [7:0] FC_PROGRAM_PHRASE = 8'h02;
    localparam logic [7:0] FC_PROGRAM_SECTION = 8'h03;
    localparam logic [7:0] FC_ERASE_SECTOR = 8'h04;

    localparam int LONGWORD_BITS = 32;
    localparam int PHRASE_BITS = 64;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } fpac_dbg_req_t;

    typedef struct packed {
        logic valid;
        fpac_sp_op_t op;
        logic [7:0] code;
        logic [23:0] addr;
        logic [63:0] data;
    } fpac_sp_cmd_t;

    typedef struct packed {
        logic valid;
        logic block;
    } fpac_rd_req_t;

    typedef struct packed {
        logic launch;
        logic direct;
        logic [7:0] code;
        logic [23:0] addr;
        logic [63:0] data;
    } fpac_fcmd_t;

endpackage : fpac_pkg

/* src/fpac_sync3.sv */
// Three-stage level synchroniser, one lane per bit.
// Assumes the input is quasi-static relative to the destination clock.
module fpac_sync3 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_lane
            // The first stage feeds only the second; the output moves once stages two and three agree.
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_reg[g] <= 1'b0;
                    s2_reg[g] <= 1'b0;
                    s3_reg[g] <= 1'b0;
                    q_o[g] <= 1'b0;
                end else begin
                    s1_reg[g] <= d_i[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    if (s2_reg[g] == s3_reg[g]) begin
                        q_o[g] <= s3_reg[g];
                    end
                end
            end
        end
    endgenerate

endmodule : fpac_sync3

/* src/fpac_top.sv */
// Flash programming access control: port choice at reset, debug control registers,
// reset and core-hold control, flash read arbitration and serial command launch.
// Assumes the debug protocol engine delivers register requests on dbg_clk_i
// and the flash controller reports busy and completion on ref_clk_i.
//
// Overview of operation
// RQ1: Port select pin sampled in reset chooses interface.
// RQ2: Serial programming mode keeps the core halted.
// RQ3: Serial port auto-launches commands, plus direct access.
// RQ4: Handshake variant stalls busy reads when enabled.
// RQ5: Wait-state variants error reads of busy block.
// RQ6: Wait-state variants serve reads of idle blocks.
// RQ7: Program width 32 or 64; section on larger.
// RQ8: High-end offers both wire protocols, low-end one.
// RQ9: Same register accesses for either wire protocol.
// RQ10: Programmer holds reset while connecting, may read ID.
// RQ11: Without reset pin, programmer sets reset request.
// RQ12: Flash ready bit set once flash initialised.
// RQ13: Security blocks debug access until erase or unlock.
// RQ14: Core hold stops boot at reset release.
// RQ15: Core hold writes ignored while secured.
// RQ16: Programmer releases reset after setting core hold.
// RQ17: Mass erase bit set by programmer, cleared on completion.
// RQ18: Reset request bit holds system in reset.
module fpac_top #(
    parameter fpac_pkg::fpac_variant_t VARIANT = fpac_pkg::FPAC_VAR_MID,
    parameter bit HIGH_END = 1'b1
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic dbg_clk_i,
    input wire logic rst_pin_n_i,
    input wire logic prog_port_select_pin_i,
    input wire logic flash_init_done_i,
    input wire logic sys_secure_i,
    input wire logic mass_erase_done_i,
    input wire logic [1:0] flash_busy_i,
    input wire logic flash_read_stall_enable_i,
    input wire fpac_pkg::fpac_dbg_req_t dbg_req_i,
    input wire fpac_pkg::fpac_sp_cmd_t sp_cmd_i,
    input wire fpac_pkg::fpac_rd_req_t rd_req_i,
    output logic [7:0] dbg_rdata_o,
    output logic sys_reset_o,
    output logic core_halt_o,
    output logic swd_en_o,
    output logic jtag_en_o,
    output logic serial_prog_en_o,
    output logic dbg_mem_access_en_o,
    output logic mass_erase_start_o,
    output fpac_pkg::fpac_fcmd_t fcmd_o,
    output logic rd_ok_o,
    output logic rd_stall_o,
    output logic rd_err_o
);

    // Reset release, one copy per clock domain.
    logic [1:0] rrst_reg;
    logic [1:0] lrst_reg;
    logic rrst_n;
    logic lrst_n;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rrst_reg <= 2'h0;
        end else begin
            rrst_reg <= {rrst_reg[0], 1'b1};
        end
    end

    always_ff @(posedge dbg_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lrst_reg <= 2'h0;
        end else begin
            lrst_reg <= {lrst_reg[0], 1'b1};
        end
    end

    assign rrst_n = rrst_reg[1];
    assign lrst_n = lrst_reg[1];

    // Link domain: debug control access port registers.
    logic sys_reset_req_reg;
    logic core_hold_reg;
    logic erase_req_tog_reg;
    logic flash_ready_l;
    logic secure_l;
    logic erase_ack_l;
    logic erase_busy_l;
    logic erase_ack_tog_reg;
    logic secure_r_reg;
    logic flash_ready_r_reg;

    fpac_sync3 #(
        .W(3)
    ) u_to_link (
        .clk_i(dbg_clk_i),
        .rst_n_i(lrst_n),
        .d_i({flash_ready_r_reg, secure_r_reg, erase_ack_tog_reg}),
        .q_o({flash_ready_l, secure_l, erase_ack_l})
    );

    // The erase bit reads set from the request until the system side acknowledges completion.
    assign erase_busy_l = erase_req_tog_reg ^ erase_ack_l; // see RQ17

    always_ff @(posedge dbg_clk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            sys_reset_req_reg <= fpac_pkg::CT_SYS_RESET_REQ_RST;
        end else if (dbg_req_i.wr && dbg_req_i.addr == fpac_pkg::DBG_CTRL_IDX) begin
            sys_reset_req_reg <= dbg_req_i.wdata[fpac_pkg::CT_SYS_RESET_REQ_POS]; // see RQ11
        end
    end

    always_ff @(posedge dbg_clk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            core_hold_reg <= fpac_pkg::CT_CORE_HOLD_RST;
        end else if (dbg_req_i.wr && dbg_req_i.addr == fpac_pkg::DBG_CTRL_IDX && !secure_l) begin
            core_hold_reg <= dbg_req_i.wdata[fpac_pkg::CT_CORE_HOLD_POS]; // see RQ15
        end
    end

    // Mass erase works while secured, as it is the way out of that state.
    always_ff @(posedge dbg_clk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            erase_req_tog_reg <= 1'b0;
        end else if (dbg_req_i.wr && dbg_req_i.addr == fpac_pkg::DBG_CTRL_IDX
                     && dbg_req_i.wdata[fpac_pkg::CT_MASS_ERASE_POS] && !erase_busy_l) begin
            erase_req_tog_reg <= ~erase_req_tog_reg; // see RQ17
        end
    end

    // Register reads look the same whichever wire protocol carried them.
    always_ff @(posedge dbg_clk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            dbg_rdata_o <= 8'h00;
        end else if (dbg_req_i.rd) begin // see RQ9
            dbg_rdata_o <= 8'h00;
            case (dbg_req_i.addr)
                fpac_pkg::DBG_STATUS_IDX: begin
                    dbg_rdata_o[fpac_pkg::ST_ERASE_BUSY_POS] <= erase_busy_l;
                    dbg_rdata_o[fpac_pkg::ST_FLASH_READY_POS] <= flash_ready_l; // see RQ12
                    dbg_rdata_o[fpac_pkg::ST_SYS_SECURE_POS] <= secure_l; // see RQ13
                end
                fpac_pkg::DBG_CTRL_IDX: begin
                    dbg_rdata_o[fpac_pkg::CT_MASS_ERASE_POS] <= erase_busy_l; // see RQ17
                    dbg_rdata_o[fpac_pkg::CT_SYS_RESET_REQ_POS] <= sys_reset_req_reg;
                    dbg_rdata_o[fpac_pkg::CT_CORE_HOLD_POS] <= core_hold_reg;
                end
                fpac_pkg::DBG_ID_IDX: begin
                    dbg_rdata_o <= fpac_pkg::DBG_ID_VALUE; // see RQ10
                end
                default: begin
                    dbg_rdata_o <= 8'h00;
                end
            endcase
        end
    end

    // System domain: inputs from pins and from the link.
    logic rst_pin_n_s;
    logic port_sel_s;
    logic sys_reset_req_s;
    logic core_hold_s;
    logic erase_req_s;

    fpac_sync3 #(
        .W(5)
    ) u_to_sys (
        .clk_i(ref_clk_i),
        .rst_n_i(rrst_n),
        .d_i({rst_pin_n_i, prog_port_select_pin_i, sys_reset_req_reg, core_hold_reg, erase_req_tog_reg}),
        .q_o({rst_pin_n_s, port_sel_s, sys_reset_req_s, core_hold_s, erase_req_s})
    );

    always_ff @(posedge ref_clk_i or negedge rrst_n) begin
        if (!rrst_n) begin
            secure_r_reg <= 1'b1;
            flash_ready_r_reg <= 1'b0;
        end else begin
            secure_r_reg <= sys_secure_i;
            flash_ready_r_reg <= flash_init_done_i; // see RQ12
        end
    end

    // System reset follows the pin and the debug reset request alike.
    logic sys_reset_next;
    assign sys_reset_next = !rst_pin_n_s || sys_reset_req_s; // see RQ18

    always_ff @(posedge ref_clk_i or negedge rrst_n) begin
        if (!rrst_n) begin
            sys_reset_o <= 1'b1;
        end else begin
            sys_reset_o <= sys_reset_next; // see RQ16
        end
    end

    // The pin function is followed throughout reset and frozen when reset lifts.
    logic serial_mode_reg;

    always_ff @(posedge ref_clk_i or negedge rrst_n) begin
        if (!rrst_n) begin
            serial_mode_reg <= 1'b0;
        end else if (sys_reset_next) begin
            serial_mode_reg <= !port_sel_s; // see RQ1
        end
    end

    always_ff @(posedge ref_clk_i or negedge rrst_n) begin
        if (!rrst_n) begin
            swd_en_o <= 1'b0;
            jtag_en_o <= 1'b0;
            serial_prog_en_o <= 1'b0;
        end else begin
            swd_en_o <= !serial_mode_reg; // see RQ1
            jtag_en_o <= !serial_mode_reg && HIGH_END; // see RQ8
            serial_prog_en_o <= serial_mode_reg; // see RQ1
        end
    end

    // Core boot: once started it runs; core hold only matters before the first instruction.
    logic booted_reg;

    always_ff @(posedge ref_clk_i or negedge rrst_n) begin
        if (!rrst_n) begin
            booted_reg <= 1'b0;
        end else if (sys_reset_next) begin
            booted_reg <= 1'b0;
        end else if (!core_hold_s && !serial_mode_reg) begin
            booted_reg <= 1'b1; // see RQ14
        end
    end

    always_ff @(posedge ref_clk_i or negedge rrst_n) begin
        if (!rrst_n) begin
            core_halt_o <= 1'b1;
        end else begin
            core_halt_o <= serial_mode_reg || sys_reset_next || (!booted_reg && core_hold_s); // see RQ2
        end
    end

    always_ff @(posedge ref_clk_i or negedge rrst_n) begin
        if (!rrst_n) begin
            dbg_mem_access_en_o <= 1'b0;
        end else begin
            dbg_mem_access_en_o <= !sys_secure_i && !serial_mode_reg; // see RQ13
        end
    end

    // Mass erase handshake: the request toggle starts it, completion toggles the acknowledge.
    logic erase_busy_reg;

    always_ff @(posedge ref_clk_i or negedge rrst_n) begin
        if (!rrst_n) begin
            erase_busy_reg <= 1'b0;
            erase_ack_tog_reg <= 1'b0;
            mass_erase_start_o <= 1'b0;
        end else begin
            mass_erase_start_o <= 1'b0;
            if (!erase_busy_reg && (erase_req_s != erase_ack_tog_reg)) begin
                erase_busy_reg <= 1'b1;
                mass_erase_start_o <= 1'b1; // see RQ17
            end else if (erase_busy_reg && mass_erase_done_i) begin
                erase_busy_reg <= 1'b0;
                erase_ack_tog_reg <= ~erase_ack_tog_reg; // see RQ17
            end
        end
    end

    // Serial programming port command launch.
    logic sp_take;
    logic [63:0] prog_mask;
    logic [7:0] prog_code;
    logic section_ok;

    assign sp_take = sp_cmd_i.valid && serial_mode_reg && !sys_reset_o && !sys_secure_i; // see RQ13
    assign prog_mask = (VARIANT == fpac_pkg::FPAC_VAR_LARGE) ? 64'hffffffffffffffff
                                                             : 64'h00000000ffffffff; // see RQ7
    assign prog_code = (VARIANT == fpac_pkg::FPAC_VAR_LARGE) ? fpac_pkg::FC_PROGRAM_PHRASE
                                                             : fpac_pkg::FC_PROGRAM_LONGWORD; // see RQ7
    assign section_ok = VARIANT != fpac_pkg::FPAC_VAR_SMALL; // see RQ7

    always_ff @(posedge ref_clk_i or negedge rrst_n) begin
        if (!rrst_n) begin
            fcmd_o <= '0;
        end else begin
            fcmd_o.launch <= 1'b0;
            fcmd_o.direct <= 1'b0;
            if (sp_take) begin
                fcmd_o.addr <= sp_cmd_i.addr;
                case (sp_cmd_i.op)
                    fpac_pkg::SP_OP_PROGRAM: begin
                        fcmd_o.launch <= 1'b1; // see RQ3
                        fcmd_o.code <= prog_code;
                        fcmd_o.data <= sp_cmd_i.data & prog_mask; // see RQ7
                    end
                    fpac_pkg::SP_OP_SECTION: begin
                        fcmd_o.launch <= section_ok; // see RQ7
                        fcmd_o.code <= fpac_pkg::FC_PROGRAM_SECTION;
                        fcmd_o.data <= sp_cmd_i.data;
                    end
                    fpac_pkg::SP_OP_ERASE_SECTOR: begin
                        fcmd_o.launch <= 1'b1; // see RQ3
                        fcmd_o.code <= fpac_pkg::FC_ERASE_SECTOR;
                        fcmd_o.data <= 64'h0000000000000000;
                    end
                    fpac_pkg::SP_OP_DIRECT: begin
                        fcmd_o.direct <= 1'b1; // see RQ3
                        fcmd_o.code <= sp_cmd_i.code;
                        fcmd_o.data <= sp_cmd_i.data;
                    end
                    default: begin
                        fcmd_o.launch <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Flash read arbitration; answers arrive one cycle after the request.
    logic any_busy;
    logic block_busy;

    assign any_busy = |flash_busy_i;
    assign block_busy = flash_busy_i[rd_req_i.block];

    always_ff @(posedge ref_clk_i or negedge rrst_n) begin
        if (!rrst_n) begin
            rd_ok_o <= 1'b0;
            rd_stall_o <= 1'b0;
            rd_err_o <= 1'b0;
        end else begin
            rd_ok_o <= 1'b0;
            rd_stall_o <= 1'b0;
            rd_err_o <= 1'b0;
            if (rd_req_i.valid) begin
                if (VARIANT == fpac_pkg::FPAC_VAR_SMALL) begin
                    // Without the stall a busy read has nothing valid to return, so it errors.
                    if (!any_busy) begin
                        rd_ok_o <= 1'b1;
                    end else if (flash_read_stall_enable_i) begin
                        rd_stall_o <= 1'b1; // see RQ4
                    end else begin
                        rd_err_o <= 1'b1;
                    end
                end else if (block_busy) begin
                    rd_err_o <= 1'b1; // see RQ5
                end else begin
                    rd_ok_o <= 1'b1; // see RQ6
                end
            end
        end
    end

endmodule : fpac_top

/* verification/fpac_assertions.sv */
// Checker for the access control top.
// Assumes binding to every instance of fpac_top; sees only its ports.
module fpac_assertions #(
    parameter fpac_pkg::fpac_variant_t VARIANT = fpac_pkg::FPAC_VAR_MID,
    parameter bit HIGH_END = 1'b1
) (
    input logic ref_clk_i,
    input logic rst_n_i,
    input logic dbg_clk_i,
    input logic rst_pin_n_i,
    input logic sys_secure_i,
    input logic [1:0] flash_busy_i,
    input fpac_pkg::fpac_dbg_req_t dbg_req_i,
    input fpac_pkg::fpac_sp_cmd_t sp_cmd_i,
    input fpac_pkg::fpac_rd_req_t rd_req_i,
    input logic [7:0] dbg_rdata_o,
    input logic sys_reset_o,
    input logic core_halt_o,
    input logic swd_en_o,
    input logic jtag_en_o,
    input logic serial_prog_en_o,
    input logic dbg_mem_access_en_o,
    input logic mass_erase_start_o,
    input fpac_pkg::fpac_fcmd_t fcmd_o,
    input logic rd_ok_o,
    input logic rd_stall_o,
    input logic rd_err_o
);
    logic sp_take;
    assign sp_take = sp_cmd_i.valid && serial_prog_en_o && !sys_reset_o && !sys_secure_i;
    port_excl_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !(swd_en_o && serial_prog_en_o)) else $error("both ports enabled");
    jtag_pair_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        jtag_en_o == (swd_en_o && HIGH_END)) else $error("jtag enable wrong");
    serial_halt_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        serial_prog_en_o |-> core_halt_o) else $error("core runs in serial mode");
    rd_busy_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        VARIANT != fpac_pkg::FPAC_VAR_SMALL && rd_req_i.valid && flash_busy_i[rd_req_i.block]
        |=> rd_err_o && !rd_ok_o && !rd_stall_o) else $error("busy read not refused");
    rd_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        VARIANT != fpac_pkg::FPAC_VAR_SMALL && rd_req_i.valid && !flash_busy_i[rd_req_i.block]
        |=> rd_ok_o && !rd_err_o && !rd_stall_o) else $error("idle read not served");
    prog_width_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        sp_take && sp_cmd_i.op == fpac_pkg::SP_OP_PROGRAM |=> fcmd_o.launch
        && (VARIANT == fpac_pkg::FPAC_VAR_LARGE || fcmd_o.data[63:32] == 32'h0)) else $error("program width");
    direct_pass_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        sp_take && sp_cmd_i.op == fpac_pkg::SP_OP_DIRECT |=> fcmd_o.direct
        && fcmd_o.code == $past(sp_cmd_i.code)) else $error("direct access lost");
    no_launch_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !$past(serial_prog_en_o) |-> !fcmd_o.launch && !fcmd_o.direct) else $error("launch outside serial mode");
    secure_block_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        sys_secure_i [*6] |-> !dbg_mem_access_en_o) else $error("access open while secured");
    pin_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !rst_pin_n_i [*6] |-> sys_reset_o) else $error("reset pin ignored");
    erase_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        mass_erase_start_o |=> !mass_erase_start_o) else $error("erase start too long");
    id_read_a: assert property (@(posedge dbg_clk_i) disable iff (!rst_n_i)
        dbg_req_i.rd && dbg_req_i.addr == fpac_pkg::DBG_ID_IDX |=> dbg_rdata_o == fpac_pkg::DBG_ID_VALUE)
        else $error("identification wrong");
endmodule : fpac_assertions

bind fpac_top fpac_assertions #(.VARIANT(VARIANT), .HIGH_END(HIGH_END)) u_chk (.ref_clk_i, .rst_n_i, .dbg_clk_i,
    .rst_pin_n_i, .sys_secure_i, .flash_busy_i, .dbg_req_i, .sp_cmd_i, .rd_req_i, .dbg_rdata_o, .sys_reset_o,
    .core_halt_o, .swd_en_o, .jtag_en_o, .serial_prog_en_o, .dbg_mem_access_en_o, .mass_erase_start_o, .fcmd_o,
    .rd_ok_o, .rd_stall_o, .rd_err_o);

/* verification/fpac_probe.sv */
// Debug probe model: byte reads, writes and bounded polls.
// Assumes the bench makes the link clock and calls one task at a time.
module fpac_probe (
    input logic dbg_clk_i,
    input logic [7:0] dbg_rdata_i,
    output fpac_pkg::fpac_dbg_req_t dbg_req_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        dbg_req_o = '0;
    end
    // Idle lines show inverted values, so stale data never looks fresh.
    task automatic put(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
        @(posedge dbg_clk_i);
        #1;
        dbg_req_o = '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge dbg_clk_i);
        #1;
        dbg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : put
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        put(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        put(1'b0, 1'b1, a, 8'h00);
        @(posedge dbg_clk_i);
        #1;
        d = dbg_rdata_i;
    endtask : rd
    // Gives up after 64 reads, leaving ok low.
    task automatic poll(input logic [1:0] a, input int b, input logic v, output logic ok);
        logic [7:0] d;
        ok = 1'b0;
        for (int i = 0; i < 64 && !ok; i++) begin
            rd(a, d);
            ok = (d[b] === v);
        end
    endtask : poll
endmodule : fpac_probe

/* verification/flash_programming_access_control_bench.sv */
// Self-checking bench for the access control top.
// Assumes the package, top, checker and probe are compiled first.
module flash_programming_access_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i = 1'b0;
    logic dbg_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic rst_pin_n_i = 1'b0;
    logic prog_port_select_pin_i = 1'b1;
    logic flash_init_done_i = 1'b0;
    logic sys_secure_i = 1'b0;
    logic mass_erase_done_i = 1'b0;
    logic [1:0] flash_busy_i = 2'h0;
    logic stall_en = 1'b0;
    fpac_pkg::fpac_sp_cmd_t sp_cmd_i = '0;
    fpac_pkg::fpac_rd_req_t rd_req_i = '0;
    fpac_pkg::fpac_dbg_req_t dbg_req;
    fpac_pkg::fpac_fcmd_t fcmd;
    logic [7:0] rdata;
    logic sys_reset, core_halt, swd_en, jtag_en, sp_en, mem_en, erase_start, rd_ok, rd_stall, rd_err;
    int mismatches = 0;
    int checks_done = 0;
    int seed = 71821;
    logic [31:0] r;
    logic [7:0] d;
    logic ok;
    always #5 ref_clk_i = ~ref_clk_i;
    always #24 dbg_clk_i = ~dbg_clk_i;
    fpac_top uut (.ref_clk_i, .rst_n_i, .dbg_clk_i, .rst_pin_n_i, .prog_port_select_pin_i, .flash_init_done_i,
        .sys_secure_i, .mass_erase_done_i, .flash_busy_i, .flash_read_stall_enable_i(stall_en),
        .dbg_req_i(dbg_req), .sp_cmd_i, .rd_req_i, .dbg_rdata_o(rdata), .sys_reset_o(sys_reset),
        .core_halt_o(core_halt), .swd_en_o(swd_en), .jtag_en_o(jtag_en), .serial_prog_en_o(sp_en),
        .dbg_mem_access_en_o(mem_en), .mass_erase_start_o(erase_start), .fcmd_o(fcmd), .rd_ok_o(rd_ok),
        .rd_stall_o(rd_stall), .rd_err_o(rd_err));
    fpac_probe probe (.dbg_clk_i, .dbg_rdata_i(rdata), .dbg_req_o(dbg_req));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [87:0] got, input logic [87:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic need(input logic c);
        chk(c, 1'b1);
        if (c !== 1'b1) begin
            wrap_up();
        end
    endtask : need
    task automatic tick;
        @(posedge ref_clk_i);
        #1;
    endtask : tick
    // Enough edges for the slowest crossing, with margin.
    task automatic settle;
        repeat (40) tick();
    endtask : settle
    task automatic ctl(input logic [7:0] v);
        probe.wr(fpac_pkg::DBG_CTRL_IDX, v);
        settle();
    endtask : ctl
    task automatic do_reset(input logic sel);
        tick();
        rst_n_i = 1'b0;
        rst_pin_n_i = 1'b0;
        prog_port_select_pin_i = sel;
        repeat (10) @(posedge dbg_clk_i);
        tick();
        rst_n_i = 1'b1;
        settle();
    endtask : do_reset
    function automatic logic [2:0] exp_rd(input logic [1:0] busy, input logic blk);
        return busy[blk] ? 3'b001 : 3'b100;
    endfunction : exp_rd
    function automatic logic [9:0] exp_fc(input fpac_pkg::fpac_sp_cmd_t c);
        case (c.op)
            fpac_pkg::SP_OP_PROGRAM: return {2'b10, fpac_pkg::FC_PROGRAM_LONGWORD};
            fpac_pkg::SP_OP_SECTION: return {2'b10, fpac_pkg::FC_PROGRAM_SECTION};
            fpac_pkg::SP_OP_ERASE_SECTOR: return {2'b10, fpac_pkg::FC_ERASE_SECTOR};
            default: return {2'b01, c.code};
        endcase
    endfunction : exp_fc
    initial begin
        do_reset(1'b1);
        chk({swd_en, jtag_en, sp_en}, 3'b110);
        probe.rd(fpac_pkg::DBG_ID_IDX, d);
        chk(d, fpac_pkg::DBG_ID_VALUE);
        probe.rd(2'h2, d);
        chk(d, 8'h00);
        probe.rd(fpac_pkg::DBG_STATUS_IDX, d);
        chk(d[fpac_pkg::ST_FLASH_READY_POS], 1'b0);
        tick();
        flash_init_done_i = 1'b1;
        probe.poll(fpac_pkg::DBG_STATUS_IDX, fpac_pkg::ST_FLASH_READY_POS, 1'b1, ok);
        need(ok);
        $display("test connect done");
        probe.wr(fpac_pkg::DBG_CTRL_IDX, 8'h10);
        tick();
        rst_pin_n_i = 1'b1;
        settle();
        chk({sys_reset, core_halt}, 2'b01);
        ctl(8'h00);
        chk(core_halt, 1'b0);
        ctl(8'h08);
        chk({sys_reset, core_halt}, 2'b11);
        ctl(8'h00);
        chk({sys_reset, mem_en}, 2'b01);
        $display("test core hold done");
        tick();
        sys_secure_i = 1'b1;
        settle();
        chk(mem_en, 1'b0);
        ctl(8'h18);
        probe.rd(fpac_pkg::DBG_CTRL_IDX, d);
        chk(d[fpac_pkg::CT_CORE_HOLD_POS], 1'b0);
        ctl(8'h00);
        chk({sys_reset, core_halt}, 2'b00);
        tick();
        sys_secure_i = 1'b0;
        settle();
        chk(mem_en, 1'b1);
        $display("test secure done");
        probe.wr(fpac_pkg::DBG_CTRL_IDX, 8'h01);
        for (int i = 0; i < 64 && erase_start !== 1'b1; i++) @(negedge ref_clk_i);
        need(erase_start);
        probe.rd(fpac_pkg::DBG_CTRL_IDX, d);
        chk(d[fpac_pkg::CT_MASS_ERASE_POS], 1'b1);
        tick();
        mass_erase_done_i = 1'b1;
        tick();
        mass_erase_done_i = 1'b0;
        probe.poll(fpac_pkg::DBG_CTRL_IDX, fpac_pkg::CT_MASS_ERASE_POS, 1'b0, ok);
        need(ok);
        $display("test erase done");
        for (int n = 0; n < 24; n++) begin
            tick();
            r = $random(seed);
            flash_busy_i = (n < 2) ? 2'h3 : r[1:0];
            stall_en = r[3];
            rd_req_i = '{valid: 1'b1, block: r[2]};
            tick();
            rd_req_i.valid = 1'b0;
            chk({rd_ok, rd_stall, rd_err}, exp_rd(flash_busy_i, rd_req_i.block));
        end
        $display("test reads done");
        do_reset(1'b0);
        tick();
        rst_pin_n_i = 1'b1;
        settle();
        chk({swd_en, jtag_en, sp_en, core_halt, sys_reset}, 5'b00110);
        for (int n = 0; n < 16; n++) begin
            tick();
            r = $random(seed);
            sp_cmd_i = '{1'b1, fpac_pkg::fpac_sp_op_t'(n[1:0]), r[7:0], r[31:8], {$random(seed), $random(seed)}};
            tick();
            sp_cmd_i.valid = 1'b0;
            chk({fcmd.launch, fcmd.direct, fcmd.code}, exp_fc(sp_cmd_i));
            if (sp_cmd_i.op == fpac_pkg::SP_OP_PROGRAM) begin
                chk({fcmd.addr, fcmd.data}, {sp_cmd_i.addr, 32'h0, sp_cmd_i.data[31:0]});
            end
        end
        $display("test serial port done");
        wrap_up();
    end
endmodule : flash_programming_access_control_bench
